/* rtl/ust_ctrl.sv */
// serial port transmit data, status flags and first control register
// Notes on behaviour
// - low byte write feeds buffer, then shifter
// - nine-bit low-first advances on high write
// - receive flag follows unread receive buffer
// - done flag after frame, empty buffer; w1c
// - empty flag high while buffer empty
// - start flag on sleep start bit; w1c
// - sync length error in auto-baud; w1c
// - LIN mode: sync char not 0x55 errors
// - break flag set; cleared by data, w1c
// - write-only wait-for-break control bit
// - five interrupts gated by enable bits
// - auto-baud error interrupt on sync error
// - loop-back routes transmit into receiver
// - control bit 0 enables line driver mode
// - interrupt stays while flag stays set
// - size codes 6, 7 are nine-bit
// - mode codes 2, 3 are auto-baud
`timescale 1ns/10ps
module ust_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [2:0] char_size,
    input wire logic [1:0] rx_mode,
    input wire logic host_spi_mode,
    input wire logic sof_enable,
    input wire logic standby_sleep,
    input wire logic rx_buf_unread,
    input wire logic rx_start_evt,
    input wire logic sync_length_err_evt,
    input wire logic sync_char_evt,
    input wire logic [7:0] sync_char,
    input wire logic break_sync_evt,
    input wire logic rx_data_evt,
    input wire logic bit_tick,
    input wire logic rxd_pin,
    output logic txd,
    output logic rx_to_receiver,
    output logic break_wait_enable,
    output logic line_driver_mode_enable,
    output logic irq_rx_unread,
    output logic irq_tx_done,
    output logic irq_tx_empty,
    output logic irq_rx_start,
    output logic irq_sync_error
);

    // data bits per frame for a size code; reserved codes fall back to eight
    function automatic logic [3:0] size_to_bits(input logic [2:0] code);
        logic [3:0] bits;
        bits = 4'h8;
        if (code == ust_pkg::CHSZ_NINE_BIT_LOW_FIRST || code == ust_pkg::CHSZ_NINE_BIT_HIGH_FIRST)
            bits = 4'h9;
        else if (code <= ust_pkg::CHSZ_8BIT)
            bits = 4'h5 + {2'b00, code[1:0]};
        return bits;
    endfunction

    logic [7:0] stage_low_q;
    logic [7:0] stage_high_q;
    logic [8:0] buf_data_q;
    logic buf_full_q;
    logic tx_done_flag_q;
    logic rx_start_flag_q;
    logic sync_field_error_flag_q;
    logic break_seen_flag_q;
    logic [7:0] ctrl_q;
    logic rxd_sync;
    logic shift_busy;
    logic shift_done;

    // address and strobe decode
    wire wr_low = reg_wr && (reg_addr == ust_pkg::OFF_TX_CHAR_LOW);
    wire wr_high = reg_wr && (reg_addr == ust_pkg::OFF_TX_CHAR_HIGH);
    wire wr_flags = reg_wr && (reg_addr == ust_pkg::OFF_PORT_FLAGS);
    wire wr_ctrl = reg_wr && (reg_addr == ust_pkg::OFF_IRQ_LOOP_CONTROL);
    wire nine_bit_low_first = (char_size == ust_pkg::CHSZ_NINE_BIT_LOW_FIRST);
    wire generic_autobaud_mode = (rx_mode == ust_pkg::RXM_GENERIC_AUTOBAUD);
    wire lin_autobaud_mode = (rx_mode == ust_pkg::RXM_LIN_AUTOBAUD);
    wire autobaud = generic_autobaud_mode || lin_autobaud_mode;

    // which byte write pushes the character into the buffer
    wire adv_wr = nine_bit_low_first ? wr_high : wr_low;
    // a push while the buffer still holds a character is dropped, never overwrites it
    wire tx_accept = adv_wr && !buf_full_q;
    wire [8:0] tx_char = wr_high ? {reg_wdata[0], stage_low_q} : {stage_high_q[0], reg_wdata};
    wire shift_load = buf_full_q && !shift_busy;
    wire tx_buffer_empty_flag = !buf_full_q;

    // flag set terms; each set wins over a clear in the same cycle
    wire tx_done_set = shift_done && !buf_full_q && !tx_accept;
    wire rx_start_set = rx_start_evt && sof_enable && standby_sleep && !host_spi_mode;
    wire sync_err_set = autobaud && sync_length_err_evt
        || lin_autobaud_mode && sync_char_evt && (sync_char != ust_pkg::LIN_SYNC_CHAR);
    wire break_set = autobaud && break_sync_evt;
    wire tx_done_clr = wr_flags && reg_wdata[ust_pkg::BIT_TX_DONE];
    wire rx_start_clr = wr_flags && reg_wdata[ust_pkg::BIT_RX_START];
    wire sync_err_clr = wr_flags && reg_wdata[ust_pkg::BIT_SYNC_ERR];
    wire break_clr = wr_flags && reg_wdata[ust_pkg::BIT_BREAK_SEEN] || rx_data_evt;

    // break wait control is write-only and reads back as zero
    wire [7:0] flags_view = {rx_buf_unread, tx_done_flag_q, tx_buffer_empty_flag,
        rx_start_flag_q, sync_field_error_flag_q, 1'b0, break_seen_flag_q, 1'b0};
    logic [7:0] rd_value;
    assign rd_value = (reg_addr == ust_pkg::OFF_TX_CHAR_LOW) ? stage_low_q
        : (reg_addr == ust_pkg::OFF_TX_CHAR_HIGH) ? {7'h00, stage_high_q[0]}
        : (reg_addr == ust_pkg::OFF_PORT_FLAGS) ? flags_view
        : (reg_addr == ust_pkg::OFF_IRQ_LOOP_CONTROL) ? ctrl_q
        : 8'h00;

    wire [4:0] irq_d = {
        ctrl_q[ust_pkg::BIT_RX_UNREAD_IE] && rx_buf_unread,
        ctrl_q[ust_pkg::BIT_TX_DONE_IE] && tx_done_flag_q,
        ctrl_q[ust_pkg::BIT_TX_EMPTY_IE] && tx_buffer_empty_flag,
        ctrl_q[ust_pkg::BIT_RX_START_IE] && rx_start_flag_q,
        ctrl_q[ust_pkg::BIT_SYNC_ERR_IE] && sync_field_error_flag_q};

    ust_sync2 u_rxd_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(rxd_pin),
        .q(rxd_sync)
    );

    ust_tx_shifter u_shifter (
        .clk(clk),
        .rst_n(rst_n),
        .bit_tick(bit_tick),
        .load(shift_load),
        .load_data(buf_data_q),
        .data_bits(size_to_bits(char_size)),
        .busy(shift_busy),
        .txd(txd),
        .done(shift_done)
    );

    // staging bytes and the one-character transmit buffer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage_low_q <= ust_pkg::RST_TX_CHAR_LOW;
            stage_high_q <= ust_pkg::RST_TX_CHAR_HIGH;
            buf_data_q <= 9'h000;
            buf_full_q <= !ust_pkg::TX_EMPTY_RESET;
        end
        else
        begin
            if (wr_low)
                stage_low_q <= reg_wdata;
            if (wr_high)
                stage_high_q <= {7'h00, reg_wdata[0]};
            if (tx_accept)
            begin
                buf_data_q <= tx_char;
                buf_full_q <= 1'b1;
            end
            else if (shift_load)
                buf_full_q <= 1'b0;
        end
    end

    // sticky flags: set has priority over clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_done_flag_q <= 1'b0;
            rx_start_flag_q <= 1'b0;
            sync_field_error_flag_q <= 1'b0;
            break_seen_flag_q <= 1'b0;
        end
        else
        begin
            tx_done_flag_q <= tx_done_set || (tx_done_flag_q && !tx_done_clr);
            rx_start_flag_q <= rx_start_set || (rx_start_flag_q && !rx_start_clr);
            sync_field_error_flag_q <= sync_err_set
                || (sync_field_error_flag_q && !sync_err_clr);
            break_seen_flag_q <= break_set || (break_seen_flag_q && !break_clr);
        end
    end

    // control registers, read port and registered outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= ust_pkg::RST_IRQ_LOOP_CONTROL;
            break_wait_enable <= 1'b0;
            reg_rdata <= 8'h00;
            rx_to_receiver <= 1'b1;
            line_driver_mode_enable <= 1'b0;
            {irq_rx_unread, irq_tx_done, irq_tx_empty, irq_rx_start, irq_sync_error} <= 5'h00;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= reg_wdata & ust_pkg::CTRL_WR_MASK;
            if (wr_flags)
                break_wait_enable <= reg_wdata[ust_pkg::BIT_BREAK_WAIT];
            reg_rdata <= reg_rd ? rd_value : 8'h00;
            // receiver sees the transmit line in loop-back, the pin otherwise
            rx_to_receiver <= ctrl_q[ust_pkg::BIT_LOOPBACK] ? txd : rxd_sync;
            line_driver_mode_enable <= ctrl_q[ust_pkg::BIT_LINE_DRIVER];
            // requests track flag and enable each cycle, so they drop with the flag
            {irq_rx_unread, irq_tx_done, irq_tx_empty, irq_rx_start, irq_sync_error} <= irq_d;
        end
    end

    a_push_fills_buffer:
    assert property (@(posedge clk) disable iff (!rst_n)
        (adv_wr && !buf_full_q) |=> !tx_buffer_empty_flag ##1 !irq_tx_empty)
        else $error("advancing write did not fill the transmit buffer");

    a_nonadv_keeps_empty:
    assert property (@(posedge clk) disable iff (!rst_n)
        (nine_bit_low_first && wr_low && !wr_high && !buf_full_q) |=> tx_buffer_empty_flag)
        else $error("staging write advanced the buffer");

    a_buffer_to_shifter:
    assert property (@(posedge clk) disable iff (!rst_n)
        (tx_accept && !shift_busy) |=> ##1 (shift_busy && tx_buffer_empty_flag))
        else $error("buffered character not handed to the shifter");

    a_tx_done_set:
    assert property (@(posedge clk) disable iff (!rst_n)
        tx_done_set |=> tx_done_flag_q ##1 (irq_tx_done == $past(ctrl_q[ust_pkg::BIT_TX_DONE_IE])))
        else $error("transmit done flag or request missing");

    a_tx_done_w1c:
    assert property (@(posedge clk) disable iff (!rst_n)
        (tx_done_clr && !tx_done_set) |=> !tx_done_flag_q)
        else $error("transmit done flag not cleared by write of one");

    a_lin_sync_error:
    assert property (@(posedge clk) disable iff (!rst_n)
        (lin_autobaud_mode && sync_char_evt && sync_char != ust_pkg::LIN_SYNC_CHAR)
            |=> sync_field_error_flag_q)
        else $error("bad LIN sync character not flagged");

    a_break_data_clear:
    assert property (@(posedge clk) disable iff (!rst_n)
        (rx_data_evt && !break_set) |=> !break_seen_flag_q)
        else $error("break flag survived received data");

    a_rx_start_sleep:
    assert property (@(posedge clk) disable iff (!rst_n)
        (!rx_start_flag_q && !(sof_enable && standby_sleep)) |=> !rx_start_flag_q)
        else $error("start flag set outside sleep start-of-frame detection");

    a_sync_irq_gate:
    assert property (@(posedge clk) disable iff (!rst_n)
        irq_sync_error |-> $past(ctrl_q[ust_pkg::BIT_SYNC_ERR_IE])
            && $past(sync_field_error_flag_q))
        else $error("sync error request without enable and flag");

    a_loopback_path:
    assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_q[ust_pkg::BIT_LOOPBACK] |=> rx_to_receiver == $past(txd))
        else $error("loop-back did not route transmit line to receiver");

    a_read_one_cycle:
    assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == ust_pkg::OFF_PORT_FLAGS)
            |=> reg_rdata[ust_pkg::BIT_RX_UNREAD] == $past(rx_buf_unread))
        else $error("receive flag readback wrong");

    a_line_driver_copy:
    assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> line_driver_mode_enable == $past(ctrl_q[ust_pkg::BIT_LINE_DRIVER]))
        else $error("line driver mode does not follow its control bit");

    a_break_wait_write:
    assert property (@(posedge clk) disable iff (!rst_n)
        wr_flags |=> break_wait_enable == $past(reg_wdata[ust_pkg::BIT_BREAK_WAIT]))
        else $error("wait-for-break control did not take the written bit");

    a_empty_irq_raise:
    assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_q[ust_pkg::BIT_TX_EMPTY_IE] && tx_buffer_empty_flag) |=> irq_tx_empty)
        else $error("enabled buffer empty request missing");

    a_rx_unread_irq:
    assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_q[ust_pkg::BIT_RX_UNREAD_IE] && rx_buf_unread) |=> irq_rx_unread)
        else $error("enabled receive request missing");

    a_irq_drops_flag:
    assert property (@(posedge clk) disable iff (!rst_n)
        !tx_done_flag_q |=> !irq_tx_done)
        else $error("transmit done request outlived its flag");

    a_break_w1c:
    assert property (@(posedge clk) disable iff (!rst_n)
        (wr_flags && reg_wdata[ust_pkg::BIT_BREAK_SEEN] && !break_set) |=> !break_seen_flag_q)
        else $error("break flag not cleared by write of one");

endmodule

/* rtl/ust_pkg.sv */
// shared constants and types for the serial port register block
package ust_pkg;

    // register offsets, as seen on reg_addr
    localparam logic [3:0] OFF_TX_CHAR_LOW = 4'h2;
    localparam logic [3:0] OFF_TX_CHAR_HIGH = 4'h3;
    localparam logic [3:0] OFF_PORT_FLAGS = 4'h4;
    localparam logic [3:0] OFF_IRQ_LOOP_CONTROL = 4'h5;

    // port_flags bit positions
    localparam int BIT_RX_UNREAD = 7;
    localparam int BIT_TX_DONE = 6;
    localparam int BIT_TX_EMPTY = 5;
    localparam int BIT_RX_START = 4;
    localparam int BIT_SYNC_ERR = 3;
    localparam int BIT_BREAK_SEEN = 1;
    localparam int BIT_BREAK_WAIT = 0;

    // irq_loop_control bit positions
    localparam int BIT_RX_UNREAD_IE = 7;
    localparam int BIT_TX_DONE_IE = 6;
    localparam int BIT_TX_EMPTY_IE = 5;
    localparam int BIT_RX_START_IE = 4;
    localparam int BIT_LOOPBACK = 3;
    localparam int BIT_SYNC_ERR_IE = 2;
    localparam int BIT_LINE_DRIVER = 0;

    // writable bits of irq_loop_control; bit 1 is reserved
    localparam logic [7:0] CTRL_WR_MASK = 8'hFD;

    // reset values
    localparam logic [7:0] RST_TX_CHAR_LOW = 8'h00;
    localparam logic [7:0] RST_TX_CHAR_HIGH = 8'h00;
    localparam logic [7:0] RST_IRQ_LOOP_CONTROL = 8'h00;
    localparam logic TX_EMPTY_RESET = 1'b1;

    // character size codes
    localparam logic [2:0] CHSZ_5BIT = 3'h0;
    localparam logic [2:0] CHSZ_6BIT = 3'h1;
    localparam logic [2:0] CHSZ_7BIT = 3'h2;
    localparam logic [2:0] CHSZ_8BIT = 3'h3;
    localparam logic [2:0] CHSZ_NINE_BIT_LOW_FIRST = 3'h6;
    localparam logic [2:0] CHSZ_NINE_BIT_HIGH_FIRST = 3'h7;

    // receiver mode codes
    localparam logic [1:0] RXM_GENERIC_AUTOBAUD = 2'h2;
    localparam logic [1:0] RXM_LIN_AUTOBAUD = 2'h3;

    // sync character expected in LIN constrained auto-baud
    localparam logic [7:0] LIN_SYNC_CHAR = 8'h55;

    // transmit shifter states
    typedef enum logic [1:0] {SH_IDLE, SH_START, SH_DATA, SH_STOP} ust_shift_e;

endpackage

/* rtl/ust_sync2.sv */
// two-stage synchroniser for a pin level
`timescale 1ns/10ps
module ust_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);

    logic meta_q;

    // idle line level is high
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b1;
            q <= 1'b1;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

/* rtl/ust_tx_shifter.sv */
// transmit shift register: start bit, 5 to 9 data bits lsb first, one stop bit
`timescale 1ns/10ps
module ust_tx_shifter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bit_tick,
    input wire logic load,
    input wire logic [8:0] load_data,
    input wire logic [3:0] data_bits,
    output logic busy,
    output logic txd,
    output logic done
);

    ust_pkg::ust_shift_e state_q;
    logic [8:0] shreg_q;
    logic [3:0] cnt_q;

    assign busy = (state_q != ust_pkg::SH_IDLE);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ust_pkg::SH_IDLE;
            shreg_q <= 9'h000;
            cnt_q <= 4'h0;
            txd <= 1'b1;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state_q)
                ust_pkg::SH_IDLE:
                begin
                    if (load)
                    begin
                        shreg_q <= load_data;
                        cnt_q <= data_bits;
                        state_q <= ust_pkg::SH_START;
                    end
                end
                ust_pkg::SH_START:
                begin
                    if (bit_tick)
                    begin
                        txd <= 1'b0;
                        state_q <= ust_pkg::SH_DATA;
                    end
                end
                ust_pkg::SH_DATA:
                begin
                    if (bit_tick && cnt_q != 4'h0)
                    begin
                        txd <= shreg_q[0];
                        shreg_q <= {1'b0, shreg_q[8:1]};
                        cnt_q <= cnt_q - 4'h1;
                    end
                    else if (bit_tick)
                    begin
                        txd <= 1'b1;
                        state_q <= ust_pkg::SH_STOP;
                    end
                end
                default:
                begin
                    // stop bit lasts one whole bit period before the frame is done
                    if (bit_tick)
                    begin
                        done <= 1'b1;
                        state_q <= ust_pkg::SH_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

/* verification/tb_top.sv */
// self-checking bench for the serial port register block
`timescale 1ns/10ps
module tb_top;
    localparam logic [3:0] LO = ust_pkg::OFF_TX_CHAR_LOW;
    localparam logic [3:0] HI = ust_pkg::OFF_TX_CHAR_HIGH;
    localparam logic [3:0] FLG = ust_pkg::OFF_PORT_FLAGS;
    localparam logic [3:0] CTL = ust_pkg::OFF_IRQ_LOOP_CONTROL;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] char_size = 3'h3;
    logic [1:0] rx_mode = 2'h0;
    logic host_spi_mode = 1'b0;
    logic sof_enable = 1'b0;
    logic standby_sleep = 1'b0;
    logic rx_buf_unread = 1'b0;
    logic [7:0] sync_char = 8'h00;
    logic [4:0] ev = 5'h00;
    logic bit_tick = 1'b0;
    logic hold_low = 1'b0;
    logic [1:0] tdiv = 2'h0;
    logic [7:0] reg_rdata, v;
    logic rxd_pin, txd, rx_to_receiver, break_wait_enable, line_driver_mode_enable;
    logic [4:0] irqs;
    logic [8:0] frame;
    logic [3:0] nbits;
    logic [7:0] pins;
    int frames, base;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;

    assign nbits = (char_size >= 3'h6) ? 4'h9 : (char_size >= 3'h3) ? 4'h8 : char_size + 4'h5;
    assign pins = {rx_to_receiver, break_wait_enable, line_driver_mode_enable, irqs};

    ust_ctrl dut (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .char_size(char_size),
        .rx_mode(rx_mode), .host_spi_mode(host_spi_mode), .sof_enable(sof_enable),
        .standby_sleep(standby_sleep), .rx_buf_unread(rx_buf_unread),
        .rx_start_evt(ev[0]), .sync_length_err_evt(ev[1]), .sync_char_evt(ev[2]),
        .sync_char(sync_char), .break_sync_evt(ev[3]), .rx_data_evt(ev[4]),
        .bit_tick(bit_tick), .rxd_pin(rxd_pin), .txd(txd), .rx_to_receiver(rx_to_receiver),
        .break_wait_enable(break_wait_enable),
        .line_driver_mode_enable(line_driver_mode_enable),
        .irq_rx_unread(irqs[4]), .irq_tx_done(irqs[3]), .irq_tx_empty(irqs[2]),
        .irq_rx_start(irqs[1]), .irq_sync_error(irqs[0])
    );

    ust_peer peer (
        .clk(clk), .bit_tick(bit_tick), .txd(txd), .nbits(nbits), .hold_low(hold_low),
        .rxd(rxd_pin), .frame(frame), .frames(frames)
    );

    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic tally_and_finish;
    begin
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    // bit period of four clocks keeps frames short; the cycle ceiling cuts a hang
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        tdiv <= tdiv + 2'h1;
        bit_tick <= (tdiv == 2'h3);
        if (cyc == LIMIT)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    begin
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    end
    endtask

    // all tasks that wait on the clock are entered just after a rising edge and leave just after one
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input bit keep = 1'b0);
    begin
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        if (!keep)
            reg_wr <= 1'b0;
    end
    endtask

    task automatic rd(input logic [3:0] a);
    begin
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
        @(posedge clk);
    end
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    begin
        rd(a);
        chk({1'b0, v}, {1'b0, exp});
    end
    endtask

    task automatic pins_chk(input logic [7:0] exp);
    begin
        // outputs lag a register change by one clock, so let one edge pass first
        @(posedge clk);
        @(negedge clk);
        chk({1'b0, pins}, {1'b0, exp});
        @(posedge clk);
    end
    endtask

    task automatic pulse(input logic [4:0] m);
    begin
        ev <= m;
        @(posedge clk);
        ev <= 5'h00;
        @(posedge clk);
    end
    endtask

    task automatic wait_done(input logic [8:0] exp);
    begin
        for (int i = 0; i < 3000 && frames == base; i++)
            @(posedge clk);
        @(negedge clk);
        chk(frame, exp);
        @(posedge clk);
        v = 8'h00;
        for (int i = 0; i < 20 && v[6] !== 1'b1; i++)
            rd(FLG);
        chk({1'b0, v}, 9'h060);
        pins_chk({3'b100, 5'b01100});
        wr(FLG, 8'h40);
        rd_chk(FLG, 8'h20);
        pins_chk({3'b100, 5'b00100});
    end
    endtask

    task automatic send(input logic [2:0] cs, input logic [3:0] a1, input logic [7:0] d1,
        input logic [3:0] a2, input logic [7:0] d2, input logic [8:0] exp);
    begin
        char_size <= cs;
        base = frames;
        wr(a1, d1);
        repeat (40) @(posedge clk);
        chk(9'(frames - base), 9'h000);
        rd_chk(a1, d1);
        wr(a2, d2);
        wait_done(exp);
        $display("test send size %0d finished", cs);
    end
    endtask

    task automatic sync_case(input logic [1:0] m, input logic [4:0] e, input logic [7:0] c,
        input logic hit);
    begin
        rx_mode <= m;
        sync_char <= c;
        pulse(e);
        rd_chk(FLG, {4'h2, hit, 3'h0});
        pins_chk({3'b100, 4'b0010, hit});
        wr(FLG, 8'h08);
    end
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(LO, 8'h00);
        rd_chk(HI, 8'h00);
        rd_chk(FLG, 8'h20);
        rd_chk(CTL, 8'h00);
        rd_chk(4'h9, 8'h00);
        pins_chk({3'b100, 5'b00000});
        wr(CTL, 8'hF4);
        pins_chk({3'b100, 5'b00100});
        $display("test reset finished");
        send(3'h3, HI, 8'h00, LO, 8'hA5, 9'h0A5);
        send(3'h0, HI, 8'h00, LO, 8'hFF, 9'h01F);
        send(3'h6, LO, 8'h3C, HI, 8'h01, 9'h13C);
        send(3'h7, HI, 8'h01, LO, 8'h5A, 9'h15A);
        send(3'h5, HI, 8'h01, LO, 8'hC3, 9'h0C3);
        char_size <= 3'h3;
        base = frames;
        wr(LO, 8'h11, 1'b1);
        wr(LO, 8'h22);
        wait_done(9'h011);
        repeat (60) @(posedge clk);
        chk(9'(frames - base), 9'h001);
        $display("test full buffer finished");
        rx_buf_unread <= 1'b1;
        rd_chk(FLG, 8'hA0);
        pins_chk({3'b100, 5'b10100});
        rx_buf_unread <= 1'b0;
        rd_chk(FLG, 8'h20);
        sof_enable <= 1'b1;
        standby_sleep <= 1'b1;
        host_spi_mode <= 1'b1;
        pulse(5'h01);
        rd_chk(FLG, 8'h20);
        host_spi_mode <= 1'b0;
        pulse(5'h01);
        rd_chk(FLG, 8'h30);
        pins_chk({3'b100, 5'b00110});
        wr(FLG, 8'h10);
        rd_chk(FLG, 8'h20);
        $display("test receive flags finished");
        sync_case(2'h2, 5'h02, 8'h55, 1'b1);
        sync_case(2'h0, 5'h02, 8'h55, 1'b0);
        sync_case(2'h3, 5'h04, 8'h55, 1'b0);
        sync_case(2'h3, 5'h04, 8'hAA, 1'b1);
        sync_case(2'h2, 5'h04, 8'hAA, 1'b0);
        pulse(5'h08);
        rd_chk(FLG, 8'h22);
        pulse(5'h10);
        rd_chk(FLG, 8'h20);
        pulse(5'h08);
        wr(FLG, 8'h02);
        rd_chk(FLG, 8'h20);
        rx_mode <= 2'h0;
        pulse(5'h08);
        rd_chk(FLG, 8'h20);
        $display("test auto-baud flags finished");
        wr(FLG, 8'h01);
        pins_chk({3'b110, 5'b00100});
        rd_chk(FLG, 8'h20);
        wr(FLG, 8'h00);
        pins_chk({3'b100, 5'b00100});
        wr(CTL, 8'hFF);
        rd_chk(CTL, 8'hFD);
        pins_chk({3'b101, 5'b00100});
        hold_low <= 1'b1;
        wr(CTL, 8'hF4);
        repeat (4) @(posedge clk);
        pins_chk({3'b000, 5'b00100});
        wr(CTL, 8'hFC);
        repeat (2) @(posedge clk);
        pins_chk({3'b100, 5'b00100});
        hold_low <= 1'b0;
        $display("test control finished");
        tally_and_finish();
    end
endmodule

/* verification/ust_peer.sv */
// serial peer: collects frames from the transmit line and drives the receive pin
`timescale 1ns/10ps
module ust_peer (
    input wire logic clk,
    input wire logic bit_tick,
    input wire logic txd,
    input wire logic [3:0] nbits,
    input wire logic hold_low,
    output logic rxd,
    output logic [8:0] frame,
    output int frames
);
    int pos = -1;
    logic [8:0] sh = 9'h000;

    // an idle receive line rests at its pull-up level
    assign rxd = hold_low ? 1'b0 : 1'b1;
    initial frames = 0;
    initial frame = 9'h000;

    // one sample per bit period, at the tick that ends it
    always @(posedge clk)
    begin
        if (bit_tick)
        begin
            if (pos < 0)
            begin
                sh = 9'h000;
                if (txd === 1'b0)
                    pos = 0;
            end
            else if (pos < int'(nbits))
            begin
                sh[pos] = txd;
                pos = pos + 1;
            end
            else
            begin
                // a frame whose stop bit is low is thrown away
                if (txd === 1'b1)
                begin
                    frame = sh;
                    frames++;
                end
                pos = -1;
            end
        end
    end
endmodule
